// [rtl/cdp_pkg.sv]
// constants shared by both ends of the programming port
package cdp_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CODE_DEPTH = 8192;
  localparam int DATA_DEPTH = 2048;
  // parallel address view
  localparam logic [13:0] DATA_BASE = 14'h2000;
  localparam logic [13:0] DATA_LAST = 14'h27FF;
  localparam logic [13:0] SIG_MAKER_ADDR = 14'h0030;
  localparam logic [13:0] SIG_PART_ADDR = 14'h0031;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] ERASE_READ = 8'h00;
  // serial instruction codes
  localparam logic [7:0] OP_ENA_B1 = 8'hAC;
  localparam logic [7:0] OP_ENA_B2 = 8'h53;
  localparam logic [2:0] OP_ERASE_LO = 3'h4;
  localparam logic [2:0] OP_LOCK_LO = 3'h7;
  localparam logic [2:0] OP_RD_CODE = 3'h1;
  localparam logic [2:0] OP_WR_CODE = 3'h2;
  localparam logic [2:0] OP_RD_DATA = 3'h5;
  localparam logic [2:0] OP_WR_DATA = 3'h6;
  localparam logic [4:0] BYTE1_END = 5'h07;
  localparam logic [4:0] BYTE2_END = 5'h0F;
  localparam logic [4:0] OUT_START = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam int INSTR_BITS = 24;
  // parallel selects {mode_select_a, verify_select_pin, mode_select_c, mode_select_d}
  localparam logic [3:0] PM_ERASE = 4'h8;
  localparam logic [3:0] PM_WRITE = 4'h7;
  localparam logic [3:0] PM_READ = 4'h3;
  localparam logic [3:0] PM_WR_LOCK = 4'hA;
  localparam logic [3:0] PM_RD_LOCK = 4'hC;
  localparam logic [3:0] PM_SIG = 4'h0;
  localparam logic [3:0] PM_FUSE = 4'h5;
  localparam logic [3:0] PM_RD_FUSE = 4'hD;
  // timing
  localparam int WRITE_US = 1500;
  localparam int SER_ERASE_US = 16000;
  localparam int PAR_HOLD_US = 10000;
  localparam int WRITE_CYC = WRITE_US * (CLK_HZ / 1_000_000);
  localparam int SER_ERASE_CYC = SER_ERASE_US * (CLK_HZ / 1_000_000);
  localparam int PAR_HOLD_CYC = PAR_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int SCK_RATIO = 40;
endpackage

// [rtl/cdp_if.sv]
// pin bundle between programmer and device
`timescale 1ns/100ps
interface cdp_if;
  logic        reset_pin;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        prog_strobe_b;
  logic        program_voltage_enable;
  logic        program_fetch_strobe_b;
  logic        mode_select_a;
  logic        verify_select_pin;
  logic        mode_select_c;
  logic        mode_select_d;
  logic [13:0] addr;
  logic [7:0]  port_host;
  logic        port_host_oe;
  logic [7:0]  port_dev;
  logic        port_dev_oe;
  logic        ready_busy_pin;
  wire  [7:0]  port_level;
  // resolved data port, pulled up when nobody drives
  assign port_level = port_dev_oe ? port_dev : (port_host_oe ? port_host : 8'hFF);
  modport dev (
    input  reset_pin, sck, mosi, prog_strobe_b, program_voltage_enable,
    input  program_fetch_strobe_b, mode_select_a, verify_select_pin,
    input  mode_select_c, mode_select_d, addr, port_level,
    output miso, port_dev, port_dev_oe, ready_busy_pin
  );
  modport host (
    output reset_pin, sck, mosi, prog_strobe_b, program_voltage_enable,
    output program_fetch_strobe_b, mode_select_a, verify_select_pin,
    output mode_select_c, mode_select_d, addr, port_host, port_host_oe,
    input  miso, port_level, ready_busy_pin
  );
endinterface

// [rtl/cdp_dev.sv]
// device end: code and data arrays with serial and parallel programming
`timescale 1ns/100ps
// Contract
// R01: parallel: code 0000-1FFF, data 2000-27FF
// R02: serial: separate code and data spaces
// R03: serial write auto-erases; locked blocks write
// R04: parallel rewrite needs chip erase first; here a parallel write overwrites the old byte
// R05: one strobe pulse per self-timed write
// R06: verify select low drives stored byte
// R07: busy read of last byte inverts MSB
// R08: ready/busy low after strobe until done
// R09: read-back only with lock one, two free
// R10: strobe held low 10 ms erases all
// R11: serial erase self-timed, reads return 00
// R12: fuse gates serial mode, parallel only
// R13: identification bytes at 030 and 031
// R14: serial needs reset high and enable
// R15: shift clock below oscillator over forty
// R16: three-byte instructions; enable is AC 53
// R17: erase instruction AC, x100, don't care
// R18: read code: aaaaa001, low, data out
// R19: write code: aaaaa010, low, data
// R20: read data: 00aaa101, low, data out
// R21: write data: 00aaa110, low, data
// R22: lock write AC, x111; zero programs
// R23: MSB first, sample rise, change fall
// R24: write and erase ignored before enable
module cdp_dev #(
  parameter int         WRITE_CYC     = cdp_pkg::WRITE_CYC,
  parameter int         SER_ERASE_CYC = cdp_pkg::SER_ERASE_CYC,
  parameter int         PAR_HOLD_CYC  = cdp_pkg::PAR_HOLD_CYC,
  parameter logic [7:0] MAKER_CODE    = 8'h5A,  // arbitrary value
  parameter logic [7:0] PART_CODE     = 8'hC3   // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  cdp_if.dev       link
);
  localparam int CD = cdp_pkg::CODE_DEPTH;
  localparam int DD = cdp_pkg::DATA_DEPTH;

  if (SER_ERASE_CYC < CD || WRITE_CYC < 1 || PAR_HOLD_CYC < 1) begin : g_bad_param
    $error("cdp_dev: erase time must cover every code address");
  end

  logic [7:0]  code_mem [CD];
  logic [7:0]  data_mem [DD];
  logic [31:0] pin_s1;
  logic [31:0] pin_s2;
  logic        sck_d;
  logic        strb_d;
  logic [4:0]  bit_cnt;
  logic [7:0]  shin;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic        prog_en;
  logic [23:0] busy_cnt;
  logic [23:0] low_cnt;
  logic        erasing;
  logic [12:0] erase_ptr;
  logic        wr_mem;
  logic        wr_is_data;
  logic [12:0] wr_addr;
  logic [7:0]  wr_val;
  logic [2:0]  lock;
  logic        ser_en;
  logic [7:0]  code_rd;
  logic [7:0]  data_rd;
  logic [12:0] rd_addr_q;
  logic        rd_data_q;
  logic        miso;
  logic [7:0]  miso_sr;
  logic [7:0]  port_dev;
  logic        port_dev_oe;
  logic        ready_busy_out;

  // two-stage synchroniser for every pin the programmer drives
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1 <= 32'h00000000;
      pin_s2 <= 32'h00000000;
    end else begin
      pin_s1 <= {link.reset_pin, link.sck, link.mosi, link.prog_strobe_b,
                 link.program_voltage_enable, link.program_fetch_strobe_b,
                 link.mode_select_a, link.verify_select_pin, link.mode_select_c,
                 link.mode_select_d, link.addr, link.port_level};
      pin_s2 <= pin_s1;
    end
  end

  // synchronised pin views and mode qualification
  wire        rst_pin  = pin_s2[31];
  wire        sck      = pin_s2[30];
  wire        mosi     = pin_s2[29];
  wire        strobe_b = pin_s2[28];
  wire        vpp      = pin_s2[27];
  wire        fetch_b  = pin_s2[26];
  wire [3:0]  msel     = pin_s2[25:22];
  wire [13:0] paddr    = pin_s2[21:8];
  wire [7:0]  pdata    = pin_s2[7:0];
  wire        ser_act  = rst_pin && !vpp && ser_en;                  // R12 R14
  wire        par_act  = rst_pin && vpp && !fetch_b;
  wire        sck_rise = ser_act && sck && !sck_d;                   // R23
  wire        sck_fall = ser_act && !sck && sck_d;
  wire        strb_rise = par_act && strobe_b && !strb_d;

  // serial instruction decode
  wire [7:0]  new_byte   = {shin[6:0], mosi};
  wire        instr_done = sck_rise && (bit_cnt == cdp_pkg::LAST_BIT);  // R16
  wire        b1_ac      = (b1 == cdp_pkg::OP_ENA_B1);
  wire        op_pe      = b1_ac && (b2 == cdp_pkg::OP_ENA_B2);          // R16
  wire        op_er      = b1_ac && (b2[2:0] == cdp_pkg::OP_ERASE_LO);   // R17
  wire        op_lk      = b1_ac && (b2[2:0] == cdp_pkg::OP_LOCK_LO);    // R22
  wire        op_wc      = (b1[2:0] == cdp_pkg::OP_WR_CODE);             // R19
  wire        op_wd      = (b1[7:6] == 2'b00) && (b1[2:0] == cdp_pkg::OP_WR_DATA);  // R21
  wire        op_rdd     = (b1[7:6] == 2'b00) && (b1[2:0] == cdp_pkg::OP_RD_DATA);  // R20
  wire [12:0] ser_caddr  = {b1[7:3], b2};                                // R02 R18
  wire [12:0] ser_daddr  = {2'b00, b1[5:3], b2};                         // R02

  // operation starts; writes and erases need the enable in serial mode
  wire        busy      = (busy_cnt != 24'h000000);
  wire        lb1_free  = lock[2];
  wire        ser_ok    = instr_done && prog_en && !busy;                // R24
  wire        ser_wr    = ser_ok && (op_wc || op_wd) && lb1_free;        // R03
  wire        ser_er    = ser_ok && op_er;                               // R11
  wire        ser_lk    = ser_ok && op_lk;                               // R22
  wire        par_rel   = strb_rise && !busy;                            // R05
  wire        long_hold = (low_cnt >= 24'(PAR_HOLD_CYC));                // R10
  wire        par_wr    = par_rel && (msel == cdp_pkg::PM_WRITE) && lb1_free &&
                          (paddr <= cdp_pkg::DATA_LAST);                 // R01
  wire        par_er    = par_rel && (msel == cdp_pkg::PM_ERASE) && long_hold;  // R10
  wire        par_lk    = par_rel && (msel == cdp_pkg::PM_WR_LOCK);
  wire        par_fz    = par_rel && (msel == cdp_pkg::PM_FUSE) && long_hold;   // R12
  wire        start_wr  = ser_wr || par_wr;
  wire        start_er  = ser_er || par_er;
  wire        commit    = wr_mem && (busy_cnt == 24'h000001);
  wire [12:0] wr_addr_in = par_act ? paddr[12:0] : (op_wd ? ser_daddr : ser_caddr);
  wire        wr_data_in = par_act ? (paddr >= cdp_pkg::DATA_BASE) : op_wd;  // R01
  wire [7:0]  wr_val_in  = par_act ? pdata : new_byte;

  // read path selection
  wire [12:0] rd_addr  = par_act ? paddr[12:0] : (op_rdd ? ser_daddr : ser_caddr);
  wire        rd_data  = par_act ? (paddr >= cdp_pkg::DATA_BASE) : op_rdd;
  wire        locked   = !(lock[2] && lock[1]);                          // R09
  wire        poll_hit = wr_mem && (rd_data_q == wr_is_data) && (rd_addr_q == wr_addr);
  wire [7:0]  poll_val = {~wr_val[7], wr_val[6:0]};                      // R07
  wire [7:0]  mem_val  = rd_data_q ? data_rd : code_rd;
  wire [7:0]  arr_val  = erasing ? cdp_pkg::ERASE_READ :
                         locked ? cdp_pkg::ERASED :
                         poll_hit ? poll_val : mem_val;                  // R07 R09 R11
  wire [7:0]  sig_val  = (paddr == cdp_pkg::SIG_MAKER_ADDR) ? MAKER_CODE :
                         (paddr == cdp_pkg::SIG_PART_ADDR) ? PART_CODE :
                         cdp_pkg::ERASED;                                // R13
  wire        par_rd   = (msel == cdp_pkg::PM_READ) || (msel == cdp_pkg::PM_SIG) ||
                         (msel == cdp_pkg::PM_RD_LOCK) || (msel == cdp_pkg::PM_RD_FUSE);
  wire [7:0]  par_val  = (msel == cdp_pkg::PM_SIG) ? sig_val :
                         (msel == cdp_pkg::PM_RD_LOCK) ? {5'h1F, lock} :
                         (msel == cdp_pkg::PM_RD_FUSE) ? {7'h7F, ~ser_en} :
                         (paddr > cdp_pkg::DATA_LAST) ? cdp_pkg::ERASED : arr_val;  // R06

  // edge history and strobe low-time counter
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_d   <= 1'b0;
      strb_d  <= 1'b1;
      low_cnt <= 24'h000000;
    end else begin
      sck_d   <= sck;
      strb_d  <= strobe_b;
      low_cnt <= strobe_b ? 24'h000000 : (long_hold ? low_cnt : low_cnt + 24'h000001);
    end
  end

  // serial shifter, msb first on rising shift clock
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt <= 5'h00;
      shin    <= 8'h00;
      b1      <= 8'h00;
      b2      <= 8'h00;
    end else if (!ser_act) begin
      bit_cnt <= 5'h00;
    end else if (sck_rise) begin
      shin    <= new_byte;                                               // R23
      bit_cnt <= instr_done ? 5'h00 : bit_cnt + 5'h01;
      if (bit_cnt == cdp_pkg::BYTE1_END) b1 <= new_byte;
      if (bit_cnt == cdp_pkg::BYTE2_END) b2 <= new_byte;
    end
  end

  // enable latch, lost whenever the reset pin drops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_en <= 1'b0;
    end else if (!rst_pin) begin
      prog_en <= 1'b0;                                                   // R14
    end else if (instr_done && op_pe) begin
      prog_en <= 1'b1;                                                   // R14 R16
    end
  end

  // self-timed write and erase sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_cnt   <= 24'h000000;
      erasing    <= 1'b0;
      erase_ptr  <= 13'h0000;
      wr_mem     <= 1'b0;
      wr_is_data <= 1'b0;
      wr_addr    <= 13'h0000;
      wr_val     <= 8'h00;
    end else if (start_er) begin
      busy_cnt  <= ser_er ? 24'(SER_ERASE_CYC) : 24'(CD);               // R11
      erasing   <= 1'b1;
      erase_ptr <= 13'h0000;
    end else if (start_wr || ser_lk || par_lk) begin
      busy_cnt   <= 24'(WRITE_CYC);                                      // R05
      wr_mem     <= start_wr;
      wr_is_data <= wr_data_in;
      wr_addr    <= wr_addr_in;
      wr_val     <= wr_val_in;
    end else if (busy) begin
      busy_cnt <= busy_cnt - 24'h000001;
      if (erase_ptr != 13'h1FFF) erase_ptr <= erase_ptr + 13'h0001;
      if (busy_cnt == 24'h000001) begin
        erasing <= 1'b0;
        wr_mem  <= 1'b0;
      end
    end
  end

  // lock bits and serial fuse; erase frees the locks, never the fuse
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock   <= 3'h7;
      ser_en <= 1'b1;                                                    // R12
    end else begin
      if (erasing && busy_cnt == 24'h000001) lock <= 3'h7;
      else if (ser_lk) lock <= lock & b2[7:5];                           // R22
      else if (par_lk) lock <= lock & pdata[7:5];
      if (par_fz) ser_en <= ~pdata[0];                                   // R12
    end
  end

  // code array: erase walk, then late commit of a pending byte
  always_ff @(posedge clk_in) begin
    if (erasing) code_mem[erase_ptr] <= cdp_pkg::ERASED;               // R10 R11
    else if (commit && !wr_is_data) code_mem[wr_addr] <= wr_val;        // R03
    code_rd <= code_mem[rd_addr];
  end

  // data array: same walk over its smaller range
  always_ff @(posedge clk_in) begin
    if (erasing && erase_ptr < 13'(DD)) data_mem[erase_ptr[10:0]] <= cdp_pkg::ERASED;
    else if (commit && wr_is_data) data_mem[wr_addr[10:0]] <= wr_val;
    data_rd <= data_mem[rd_addr[10:0]];
  end

  // pin outputs: data port, ready/busy and serial output shifter
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_addr_q      <= 13'h0000;
      rd_data_q      <= 1'b0;
      port_dev       <= 8'hFF;
      port_dev_oe    <= 1'b0;
      ready_busy_out <= 1'b1;
      miso           <= 1'b1;
      miso_sr        <= 8'hFF;
    end else begin
      rd_addr_q      <= rd_addr;
      rd_data_q      <= rd_data;
      port_dev       <= par_val;
      port_dev_oe    <= par_act && par_rd && strobe_b;                   // R06
      ready_busy_out <= !(par_act && busy);                              // R08
      if (sck_fall && bit_cnt == cdp_pkg::OUT_START) begin
        miso    <= arr_val[7];                                           // R18 R20
        miso_sr <= {arr_val[6:0], 1'b0};
      end else if (sck_fall && bit_cnt > cdp_pkg::OUT_START) begin
        miso    <= miso_sr[7];                                           // R23
        miso_sr <= {miso_sr[6:0], 1'b0};
      end
    end
  end

  assign link.miso           = miso;
  assign link.port_dev       = port_dev;
  assign link.port_dev_oe    = port_dev_oe;
  assign link.ready_busy_pin = ready_busy_out;
endmodule // cdp_dev

// [rtl/cdp_host.sv]
// programmer end: serial instructions and parallel operations
`timescale 1ns/100ps
module cdp_host #(
  parameter int SCK_HALF  = 21,
  parameter int PULSE_CYC = 5,
  parameter int HOLD_CYC  = cdp_pkg::PAR_HOLD_CYC + 4,
  parameter int SETUP_CYC = 4,
  parameter int READ_WAIT = 10
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        prog_level_in,
  input  wire logic        hv_level_in,
  input  wire logic        ser_go_in,
  input  wire logic [23:0] ser_word_in,
  input  wire logic        par_go_in,
  input  wire logic [3:0]  par_sel_in,
  input  wire logic [13:0] par_addr_in,
  input  wire logic [7:0]  par_data_in,
  input  wire logic        par_long_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [7:0]       rd_data_out,
  output logic             ready_out,
  cdp_if.host              link
);
  if (2 * SCK_HALF <= cdp_pkg::SCK_RATIO || PULSE_CYC < 1 || SETUP_CYC < 1 ||
      READ_WAIT < 8 || HOLD_CYC < 1 || HOLD_CYC > 24'hFFFFFF) begin : g_bad_param
    $error("cdp_host: shift clock too fast or counts out of range");
  end

  typedef enum logic [5:0] {
    CDP_IDLE = 6'b000001,
    CDP_SER  = 6'b000010,
    CDP_PSET = 6'b000100,
    CDP_PLOW = 6'b001000,
    CDP_PRD  = 6'b010000,
    CDP_DONE = 6'b100000
  } cdp_state_t;

  cdp_state_t  state;
  logic [23:0] tmr;
  logic [4:0]  idx;
  logic [23:0] sword;
  logic [7:0]  rd;
  logic [9:0]  in_s1;
  logic [9:0]  in_s2;
  logic        sck;
  logic        mosi;
  logic        strobe_b;
  logic [3:0]  sel;
  logic [13:0] addr;
  logic [7:0]  pdata;
  logic        pdata_oe;
  logic        rst_pin;
  logic        vpp;

  wire tmr_zero = (tmr == 24'h000000);
  wire miso_s   = in_s2[9];
  wire sel_rd   = (par_sel_in == cdp_pkg::PM_READ) || (par_sel_in == cdp_pkg::PM_SIG) ||
                  (par_sel_in == cdp_pkg::PM_RD_LOCK) || (par_sel_in == cdp_pkg::PM_RD_FUSE);
  wire held_rd  = (sel == cdp_pkg::PM_READ) || (sel == cdp_pkg::PM_SIG) ||
                  (sel == cdp_pkg::PM_RD_LOCK) || (sel == cdp_pkg::PM_RD_FUSE);

  // synchronise device outputs into the host clock
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_s1 <= 10'h3FF;
      in_s2 <= 10'h3FF;
    end else begin
      in_s1 <= {link.miso, link.ready_busy_pin, link.port_level};
      in_s2 <= in_s1;
    end
  end

  // levels and operation sequencer; shift clock is divided from clk_in
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= CDP_IDLE;
      tmr <= 24'h000000;
      idx <= 5'h00;
      sword <= 24'h000000;
      rd <= 8'h00;
      sck <= 1'b0;
      mosi <= 1'b0;
      strobe_b <= 1'b1;
      sel <= 4'hF;
      addr <= 14'h0000;
      pdata <= 8'hFF;
      pdata_oe <= 1'b0;
      rst_pin <= 1'b0;
      vpp <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rd_data_out <= 8'h00;
      ready_out <= 1'b1;
    end else begin
      rst_pin   <= prog_level_in;
      vpp       <= hv_level_in;
      ready_out <= in_s2[8];
      done_out  <= 1'b0;
      case (state)
        CDP_IDLE: begin
          if (ser_go_in) begin
            state <= CDP_SER;
            busy_out <= 1'b1;
            sword <= ser_word_in;
            mosi <= ser_word_in[cdp_pkg::INSTR_BITS-1];
            idx <= 5'h00;
            tmr <= 24'(SCK_HALF - 1);
          end else if (par_go_in) begin
            state <= CDP_PSET;
            busy_out <= 1'b1;
            sel <= par_sel_in;
            addr <= par_addr_in;
            pdata <= par_data_in;
            pdata_oe <= !sel_rd;
            tmr <= 24'(par_long_in ? HOLD_CYC - 1 : PULSE_CYC - 1);
            idx <= 5'(SETUP_CYC);
          end
        end
        CDP_SER: begin
          if (!tmr_zero) begin
            tmr <= tmr - 24'h000001;
          end else if (!sck) begin
            sck <= 1'b1;
            rd  <= {rd[6:0], miso_s};
            tmr <= 24'(SCK_HALF - 1);
          end else begin
            sck <= 1'b0;
            mosi <= sword[cdp_pkg::INSTR_BITS-2];
            sword <= {sword[22:0], 1'b0};
            tmr <= 24'(SCK_HALF - 1);
            idx <= idx + 5'h01;
            if (idx == cdp_pkg::LAST_BIT) state <= CDP_DONE;
          end
        end
        CDP_PSET: begin
          if (idx != 5'h00) begin
            idx <= idx - 5'h01;
          end else if (held_rd) begin
            state <= CDP_PRD;
            idx <= 5'(READ_WAIT);
          end else begin
            state <= CDP_PLOW;
            strobe_b <= 1'b0;
          end
        end
        CDP_PLOW: begin
          if (!tmr_zero) begin
            tmr <= tmr - 24'h000001;
          end else begin
            strobe_b <= 1'b1;
            state <= CDP_DONE;
          end
        end
        CDP_PRD: begin
          if (idx != 5'h00) begin
            idx <= idx - 5'h01;
          end else begin
            rd <= in_s2[7:0];
            state <= CDP_DONE;
          end
        end
        CDP_DONE: begin
          rd_data_out <= rd;
          done_out <= 1'b1;
          busy_out <= 1'b0;
          state <= CDP_IDLE;
        end
        default: begin
          state <= CDP_IDLE;
        end
      endcase
    end
  end

  // pin drive; fetch strobe stays low whenever high voltage is applied
  assign link.reset_pin              = rst_pin;
  assign link.sck                    = sck;
  assign link.mosi                   = mosi;
  assign link.prog_strobe_b          = strobe_b;
  assign link.program_voltage_enable = vpp;
  assign link.program_fetch_strobe_b = !vpp;
  assign link.mode_select_a          = sel[3];
  assign link.verify_select_pin      = sel[2];
  assign link.mode_select_c          = sel[1];
  assign link.mode_select_d          = sel[0];
  assign link.addr                   = addr;
  assign link.port_host              = pdata;
  assign link.port_host_oe           = pdata_oe;
endmodule // cdp_host

// [sim/cdp_props.sv]
// wire checks on the programming link between the two ends
`timescale 1ns/100ps
module cdp_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic prog_strobe_b,
  input wire logic program_voltage_enable,
  input wire logic ready_busy_pin,
  input wire logic port_dev_oe
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic [13:0] low_len;
  // length of the current busy window
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) low_len <= 14'h0000;
    else low_len <= ready_busy_pin ? 14'h0000 : low_len + 14'h0001;
  end
  // strobe shape, busy window and serial framing
  strobe_min_a: assert property ($fell(prog_strobe_b) |-> !prog_strobe_b[*5])
    else $error("strobe pulse too short");
  busy_start_a: assert property ($fell(ready_busy_pin) |-> prog_strobe_b)
    else $error("busy began with strobe low");
  busy_after_a: assert property ($rose(prog_strobe_b) |-> ##[2:8] !ready_busy_pin)
    else $error("no busy after strobe");
  busy_end_a: assert property (!ready_busy_pin |-> low_len < 14'h206C)
    else $error("busy too long");
  oe_release_a: assert property ($fell(program_voltage_enable) |-> ##[0:6] !port_dev_oe)
    else $error("port driven outside parallel mode");
  sck_high_a: assert property ($rose(sck) |-> sck[*8])
    else $error("shift clock too fast");
  mosi_hold_a: assert property ($rose(sck) |=> $stable(mosi)[*8])
    else $error("mosi moved while clock high");
  miso_fall_a: assert property ($changed(miso) |-> !sck)
    else $error("miso moved while clock high");
endmodule // cdp_props

// [sim/cdp_test.sv]
// self-checking bench: programmer and device joined on the link
`timescale 1ns/100ps
module cdp_test;
  logic        clk_in = 1'b0, rst_b_in = 1'b0, prog_level_in = 1'b0, hv_level_in = 1'b0;
  logic        ser_go_in = 1'b0, par_go_in = 1'b0, par_long_in = 1'b0;
  logic        busy_out, done_out, ready_out;
  logic [23:0] ser_word_in = 24'h000000;
  logic [3:0]  par_sel_in = 4'h3;
  logic [13:0] par_addr_in = 14'h0000, a, b;
  logic [7:0]  par_data_in = 8'hFF, rd_data_out, d;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  int          mem[int];  // model of the flat parallel address view
  cdp_if lnk();
  cdp_dev #(.WRITE_CYC(50), .SER_ERASE_CYC(8200), .PAR_HOLD_CYC(20)) i_cdp_dev (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .link(lnk));
  cdp_host #(.HOLD_CYC(30)) i_cdp_host (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .prog_level_in(prog_level_in), .hv_level_in(hv_level_in), .ser_go_in(ser_go_in),
    .ser_word_in(ser_word_in), .par_go_in(par_go_in), .par_sel_in(par_sel_in),
    .par_addr_in(par_addr_in), .par_data_in(par_data_in), .par_long_in(par_long_in),
    .busy_out(busy_out), .done_out(done_out), .rd_data_out(rd_data_out),
    .ready_out(ready_out), .link(lnk));
  cdp_props i_cdp_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .sck(lnk.sck),
    .mosi(lnk.mosi), .miso(lnk.miso), .prog_strobe_b(lnk.prog_strobe_b),
    .program_voltage_enable(lnk.program_voltage_enable),
    .ready_busy_pin(lnk.ready_busy_pin), .port_dev_oe(lnk.port_dev_oe));
  // clock and hang guard
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ex(input int ad);
    return mem.exists(ad) ? 8'(mem[ad]) : 8'hFF;  // erased reads all ones
  endfunction
  // one host operation, waits for its done pulse
  task automatic op(input logic s, input logic [23:0] w, input logic [3:0] sl,
                    input logic [13:0] ad, input logic [7:0] dt, input logic lg);
    @(posedge clk_in);
    ser_go_in <= s;
    par_go_in <= !s;
    ser_word_in <= w;
    par_sel_in <= sl;
    par_addr_in <= ad;
    par_data_in <= dt;
    par_long_in <= lg;
    @(posedge clk_in);
    ser_go_in <= 1'b0;
    par_go_in <= 1'b0;
    for (int k = 0; k < 3000 && done_out !== 1'b1; k++) @(posedge clk_in) #1;
  endtask
  task automatic sop(input logic [23:0] w);
    op(1'b1, w, 4'h3, 14'h0000, 8'hFF, 1'b0);
  endtask
  // let busy show, then wait for ready
  task automatic settle();
    repeat (12) @(posedge clk_in);
    for (int k = 0; k < 9000 && ready_out !== 1'b1; k++) @(posedge clk_in) #1;
  endtask
  // main sequence: serial session, then parallel session
  initial begin
    void'($urandom(99));
    a = 14'($urandom % 8192);
    b = 14'($urandom % 2048);
    d = 8'($urandom) & 8'hFE;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    prog_level_in <= 1'b1;
    sop(24'hAC5300);
    sop(24'hAC0400);
    mem.delete();
    sop({a[12:8], 3'b001, a[7:0], 8'h00});
    check(rd_data_out, 8'h00);
    repeat (8300) @(posedge clk_in);
    sop({a[12:8], 3'b010, a[7:0], ~d});
    sop({a[12:8], 3'b010, a[7:0], d});
    mem[a] = d;
    sop({2'b00, b[10:8], 3'b110, b[7:0], ~d});
    mem[b + 14'h2000] = ~d;
    sop({a[12:8], 3'b001, a[7:0], 8'h00});
    check(rd_data_out, ex(a));
    sop({2'b00, b[10:8], 3'b101, b[7:0], 8'h00});
    check(rd_data_out, ex(b + 14'h2000));
    prog_level_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    prog_level_in <= 1'b1;
    sop({a[12:8] ^ 5'h01, 3'b010, a[7:0], d});
    sop({a[12:8] ^ 5'h01, 3'b001, a[7:0], 8'h00});
    check(rd_data_out, ex(a ^ 14'h0100));
    $display("serial session finished");
    hv_level_in <= 1'b1;
    op(1'b0, 24'h0, cdp_pkg::PM_READ, b + 14'h2000, 8'hFF, 1'b0);
    check(rd_data_out, ex(b + 14'h2000));
    b = (b ^ 14'h0001) + 14'h2000;
    op(1'b0, 24'h0, cdp_pkg::PM_WRITE, b, d, 1'b0);
    mem[b] = d;
    op(1'b0, 24'h0, cdp_pkg::PM_READ, b, 8'hFF, 1'b0);
    check(rd_data_out, {~d[7], d[6:0]});
    settle();
    op(1'b0, 24'h0, cdp_pkg::PM_READ, b, 8'hFF, 1'b0);
    check(rd_data_out, ex(b));
    op(1'b0, 24'h0, cdp_pkg::PM_SIG, 14'h0030, 8'hFF, 1'b0);
    check(rd_data_out, 8'h5A);
    op(1'b0, 24'h0, cdp_pkg::PM_RD_FUSE, 14'h0000, 8'hFF, 1'b0);
    check(rd_data_out, 8'hFE);
    op(1'b0, 24'h0, cdp_pkg::PM_WR_LOCK, 14'h0000, 8'h3F, 1'b0);
    settle();
    op(1'b0, 24'h0, cdp_pkg::PM_RD_LOCK, 14'h0000, 8'hFF, 1'b0);
    check(rd_data_out, 8'hF9);
    op(1'b0, 24'h0, cdp_pkg::PM_READ, a, 8'hFF, 1'b0);
    check(rd_data_out, 8'hFF);
    op(1'b0, 24'h0, cdp_pkg::PM_ERASE, 14'h0000, 8'hFF, 1'b1);
    mem.delete();
    settle();
    op(1'b0, 24'h0, cdp_pkg::PM_READ, a, 8'hFF, 1'b0);
    check(rd_data_out, ex(a));
    hv_level_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    $display("parallel session finished");
    complete_run();
  end
endmodule // cdp_test
